/* rtl/sramh_cfg.svh */
/*
 timing and geometry constants for the static ram host controller.
 assumes a 25 mhz system clock; counts are derived from ns figures.
*/
`ifndef SRAMH_CFG_SVH
`define SRAMH_CFG_SVH
`define SRAMH_CLK_NS 40
`define SRAMH_ADDR_W 12
`define SRAMH_DEPTH 4096
`define SRAMH_ADDR_ACCESS_TIME_NS 55
`define SRAMH_SEL_ACCESS_RESTED_NS 55
`define SRAMH_SEL_ACCESS_RECENT_NS 65
`define SRAMH_SEL_ACTIVE_MIN_NS 55
`define SRAMH_STORE_PULSE_MIN_NS 35
`define SRAMH_STORE_SETUP_NS 45
`define SRAMH_DIN_SETUP_NS 25
`define SRAMH_DIN_HOLD_NS 10
`define SRAMH_ADDR_HOLD_AFTER_STORE_NS 10
`define SRAMH_DESEL_TO_FLOAT_NS 40
`define SRAMH_CEIL(ns) (((ns) + `SRAMH_CLK_NS - 1) / `SRAMH_CLK_NS)
`define SRAMH_SYNC_CYC 2
`define SRAMH_READ_CYC (`SRAMH_CEIL(`SRAMH_SEL_ACCESS_RECENT_NS) + `SRAMH_SYNC_CYC)
`define SRAMH_STORE_CYC `SRAMH_CEIL(`SRAMH_STORE_SETUP_NS)
`define SRAMH_HOLD_CYC `SRAMH_CEIL(`SRAMH_ADDR_HOLD_AFTER_STORE_NS)
`define SRAMH_REST_CYC `SRAMH_CEIL(`SRAMH_DESEL_TO_FLOAT_NS)
`endif

/* rtl/sramh_pkg.sv */
/*
 types for the static ram host controller.
 assumes sramh_cfg.svh is on the include path.
*/
`include "sramh_cfg.svh"
package sramh_pkg;
    typedef enum logic [4:0] {
        SRAMH_IDLE = 5'h01,
        SRAMH_READ = 5'h02,
        SRAMH_STORE = 5'h04,
        SRAMH_HOLD = 5'h08,
        SRAMH_REST = 5'h10
    } sramh_state_t;
    typedef struct packed {
        logic write;
        logic [`SRAMH_ADDR_W-1:0] addr;
        logic wdata;
    } sramh_req_t;
    typedef struct packed {
        logic sel_n;
        logic store_n;
        logic [`SRAMH_ADDR_W-1:0] addr;
        logic din;
    } sramh_pins_t;
endpackage : sramh_pkg

/* rtl/sramh_host.sv */
/*
 host controller for a 4096 x 1 asynchronous static ram.
 assumes one 25 mhz clock; the ram data output is an async pin.
*/
// Contract
// RULE_01: ram holds 4096 one-bit words by address
// RULE_02: deselect puts ram into standby
// RULE_03: read data has written polarity
// RULE_04: ram output floats unless driving read data
// RULE_05: select is a level, no clocking needed
// RULE_06: read valid within address access time
// RULE_07: old data held briefly after address change
// RULE_08: select access depends on prior deselect time
// RULE_09: output floats within 40 ns after deselect
// RULE_10: standby reached within 30 ns of deselect
// RULE_11: write strobe floats ram output
// RULE_12: hold address one cycle time while selected
// RULE_13: hold select at least select-active minimum
// RULE_14: strobe low 35 ns, setup 45 ns
// RULE_15: data setup 25 ns, hold 10 ns
// RULE_16: zero address setup; address hold 10 ns
// RULE_17: select+strobe low writes, select alone reads
`timescale 1ns/1ps
`default_nettype none
`include "sramh_cfg.svh"
module sramh_host
    import sramh_pkg::*;
#(
    parameter int ADDR_W = `SRAMH_ADDR_W
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic i_req_valid,
    input wire sramh_req_t i_req,
    output logic o_req_ready,
    output logic o_rdata_valid,
    output logic o_rdata,
    output sramh_pins_t o_pins,
    input wire logic i_ram_dout
);
    localparam logic [2:0] READ_CYC = 3'(`SRAMH_READ_CYC);
    localparam logic [2:0] STORE_CYC = 3'(`SRAMH_STORE_CYC);
    localparam logic [2:0] HOLD_CYC = 3'(`SRAMH_HOLD_CYC);
    localparam logic [2:0] REST_CYC = 3'(`SRAMH_REST_CYC);

    sramh_state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    sramh_pins_t pins_r, pins_nxt;
    logic rvalid_r, rvalid_nxt;
    logic rdata_r, rdata_nxt;
    logic dout_s1_r, dout_s2_r;

    function automatic logic [2:0] cnt_dec(input logic [2:0] c);
        return c - 3'h1;
    endfunction : cnt_dec

    // ram output passes two flops before use
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            dout_s1_r <= 1'b0;
            dout_s2_r <= 1'b0;
        end else begin
            dout_s1_r <= i_ram_dout;
            dout_s2_r <= dout_s1_r;
        end
    end

    assign o_req_ready = (state_r == SRAMH_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pins_nxt = pins_r;
        rvalid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        unique case (state_r)
            SRAMH_IDLE: begin
                if (i_req_valid) begin
                    // address, data and select together: zero setup allowed RULE_16
                    pins_nxt.addr = i_req.addr;
                    pins_nxt.din = i_req.wdata;
                    pins_nxt.sel_n = 1'b0;
                    if (i_req.write) begin
                        pins_nxt.store_n = 1'b0; // RULE_17
                        cnt_nxt = STORE_CYC;
                        state_nxt = SRAMH_STORE;
                    end else begin
                        cnt_nxt = READ_CYC;
                        state_nxt = SRAMH_READ;
                    end
                end
            end
            SRAMH_READ: begin
                // select and address held past worst select access RULE_06 RULE_08 RULE_12 RULE_13
                cnt_nxt = cnt_dec(cnt_r);
                if (cnt_r == 3'h1) begin
                    pins_nxt.sel_n = 1'b1; // RULE_02
                    cnt_nxt = REST_CYC;
                    state_nxt = SRAMH_REST;
                end
            end
            SRAMH_STORE: begin
                // strobe low covers pulse width and address setup RULE_14 RULE_15
                cnt_nxt = cnt_dec(cnt_r);
                if (cnt_r == 3'h1) begin
                    pins_nxt.store_n = 1'b1; // RULE_17
                    cnt_nxt = HOLD_CYC;
                    state_nxt = SRAMH_HOLD;
                end
            end
            SRAMH_HOLD: begin
                // address and data kept after strobe rises RULE_15 RULE_16
                cnt_nxt = cnt_dec(cnt_r);
                if (cnt_r == 3'h1) begin
                    pins_nxt.sel_n = 1'b1;
                    cnt_nxt = REST_CYC;
                    state_nxt = SRAMH_REST;
                end
            end
            SRAMH_REST: begin
                // wait for the ram output to float RULE_09 RULE_04
                cnt_nxt = cnt_dec(cnt_r);
                if (cnt_r == 3'h1) begin
                    state_nxt = SRAMH_IDLE;
                end
            end
            default: begin
                state_nxt = SRAMH_IDLE;
                pins_nxt.sel_n = 1'b1;
                pins_nxt.store_n = 1'b1;
            end
        endcase
        if (state_r == SRAMH_READ && cnt_r == 3'h1) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = dout_s2_r; // RULE_03
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r <= SRAMH_IDLE;
            cnt_r <= 3'h0;
            pins_r <= '{sel_n: 1'b1, store_n: 1'b1, addr: '0, din: 1'b0};
            rvalid_r <= 1'b0;
            rdata_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pins_r <= pins_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_pins = pins_r;
    assign o_rdata_valid = rvalid_r;
    assign o_rdata = rdata_r;

    property strobe_width_p;
        @(posedge I_CLK) disable iff (!I_RST_N)
        $fell(pins_r.store_n) |-> (!pins_r.store_n && !pins_r.sel_n) [*2];
    endproperty
    strobe_width_a: assert property (strobe_width_p) // RULE_14
        else $error("store strobe shorter than two cycles");

    addr_stable_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_12
        (!pins_r.sel_n && !$fell(pins_r.sel_n)) |-> $stable(pins_r.addr))
        else $error("address changed while selected");

    din_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_15
        $rose(pins_r.store_n) |-> $stable(pins_r.din) && $stable(pins_r.addr))
        else $error("data or address moved at strobe rise");

    sequence sel_start_s;
        $fell(pins_r.sel_n) && pins_r.store_n;
    endsequence
    sel_min_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_13
        sel_start_s |-> !pins_r.sel_n [*3])
        else $error("select active too short for a read");

    read_done_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_06
        sel_start_s |-> ##3 rvalid_nxt)
        else $error("read answer not at fixed cycle");

    store_in_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_17
        !pins_r.store_n |-> !pins_r.sel_n)
        else $error("strobe low without select");

    rest_gap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_09
        $rose(pins_r.sel_n) |-> pins_r.sel_n && !o_req_ready)
        else $error("new access before output floats");

    store_ends_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_14
        $fell(pins_r.store_n) |-> ##[2:2] $rose(pins_r.store_n))
        else $error("strobe length not two cycles");

    store_setup_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_14
        $rose(pins_r.store_n) |-> $past(pins_r.store_n, 2) == 1'b0)
        else $error("strobe rose before setup time");

    sel_through_store_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_14
        $rose(pins_r.store_n) |-> !pins_r.sel_n)
        else $error("select released before strobe end");

    hold_after_store_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_16
        $rose(pins_r.store_n) |=> $stable(pins_r.addr) && $stable(pins_r.din))
        else $error("address or data moved after strobe end");

    rest_len_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_09
        $rose(pins_r.sel_n) |-> !o_req_ready ##1 o_req_ready)
        else $error("rest after deselect not one cycle");

    sel_gap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_08
        $fell(pins_r.sel_n) |-> $past(pins_r.sel_n, 2))
        else $error("select reasserted without rest gap");

    read_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_06
        o_rdata_valid |=> !o_rdata_valid)
        else $error("read valid longer than one cycle");

    read_while_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // RULE_17
        rvalid_nxt |-> !pins_r.sel_n && pins_r.store_n)
        else $error("read data taken outside a read");
endmodule : sramh_host
`default_nettype wire

/* bench/sramh_ram_model.sv */
/*
 behavioural model of the 4096 x 1 static ram on the host's pins.
 assumes pins come from sramh_host; a floating output shows the inverse of cell data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sramh_cfg.svh"
module sramh_ram_model
    import sramh_pkg::*;
(
    input wire sramh_pins_t i_pins,
    output logic o_dout
);
    logic mem [0:`SRAMH_DEPTH-1];
    logic rd;
    wire logic standby = i_pins.sel_n;
    initial for (int i = 0; i < `SRAMH_DEPTH; i++) mem[i] = 1'b0;
    always @(posedge i_pins.store_n) begin
        if (!i_pins.sel_n) mem[i_pins.addr] = i_pins.din;
    end
    assign #55 rd = mem[i_pins.addr];
    assign o_dout = (!standby && i_pins.store_n) ? rd : ~rd;
endmodule : sramh_ram_model
`default_nettype wire

/* bench/tb_sramh_host.sv */
/*
 self-checking bench for sramh_host with the ram model on its pins.
 assumes sramh_pkg and sramh_cfg.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sramh_cfg.svh"
module tb_sramh_host
    import sramh_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic i_req_valid = 1'b0;
    sramh_req_t i_req = '0;
    logic o_req_ready, o_rdata_valid, o_rdata, ram_dout;
    sramh_pins_t o_pins;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam int st_cyc = `SRAMH_STORE_CYC;
    localparam int wr_sel = `SRAMH_STORE_CYC + `SRAMH_HOLD_CYC;
    localparam int wr_cyc = wr_sel + `SRAMH_REST_CYC;
    localparam int rd_sel = `SRAMH_READ_CYC;
    localparam int rd_cyc = rd_sel + `SRAMH_REST_CYC;
    sramh_host sramh_host_inst (.I_CLK(clk), .I_RST_N(rst_n), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
        .o_rdata(o_rdata), .o_pins(o_pins), .i_ram_dout(ram_dout));
    sramh_ram_model sramh_ram_model_inst (.i_pins(o_pins), .o_dout(ram_dout));
    initial forever #20 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic timeout();
        n_mismatch++;
        finish_test();
    endtask : timeout
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_cnt
    task automatic issue(input logic wr, input logic [11:0] a, input logic d);
        int k;
        k = 0;
        while (o_req_ready !== 1'b1) begin
            @(negedge clk);
            k++;
            if (k > 20) timeout();
        end
        i_req_valid = 1'b1;
        i_req = '{write: wr, addr: a, wdata: d};
        @(negedge clk);
        i_req_valid = 1'b0;
    endtask : issue
    task automatic access(input logic wr, input logic [11:0] a, input logic d);
        int k, sel_lo, st_lo, vk;
        logic got;
        k = 0;
        sel_lo = 0;
        st_lo = 0;
        vk = 0;
        got = 1'bx;
        issue(wr, a, d);
        while (o_req_ready !== 1'b1) begin
            k++;
            if (o_pins.sel_n === 1'b0) begin
                sel_lo++;
                check_bit(o_pins.addr === a, 1'b1);
            end
            if (o_pins.store_n === 1'b0) begin
                st_lo++;
                check_bit(o_pins.din, d);
            end
            if (o_rdata_valid === 1'b1) begin
                vk = k;
                got = o_rdata;
            end
            if (k > 12) timeout();
            @(negedge clk);
        end
        check_cnt(k, wr ? wr_cyc : rd_cyc);
        check_cnt(sel_lo, wr ? wr_sel : rd_sel);
        check_cnt(st_lo, wr ? st_cyc : 0);
        check_cnt(vk, wr ? 0 : rd_sel + 1);
        if (!wr) check_bit(got, d);
    endtask : access
    task automatic t_idle();
        check_bit(o_pins.sel_n, 1'b1);
        check_bit(o_pins.store_n, 1'b1);
        check_bit(o_req_ready, 1'b1);
        check_bit(o_rdata_valid, 1'b0);
    endtask : t_idle
    task automatic t_corners();
        logic [11:0] tab [4] = '{12'h000, 12'hfff, 12'h555, 12'haaa};
        for (int i = 0; i < 4; i++) access(1'b1, tab[i], i[0] ^ i[1]);
        for (int i = 3; i >= 0; i--) access(1'b0, tab[i], i[0] ^ i[1]);
        access(1'b1, 12'hfff, 1'b0);
        access(1'b0, 12'hfff, 1'b0);
        access(1'b0, 12'h555, 1'b1);
        access(1'b0, 12'haaa, 1'b0);
    endtask : t_corners
    task automatic t_midreset();
        issue(1'b1, 12'h123, 1'b1);
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        t_idle();
        rst_n = 1'b1;
        @(negedge clk);
        access(1'b0, 12'h555, 1'b1);
    endtask : t_midreset
    initial begin
        repeat (3) @(negedge clk);
        t_idle();
        rst_n = 1'b1;
        t_corners();
        t_midreset();
        finish_test();
    end
endmodule : tb_sramh_host
`default_nettype wire
